/* File: shared/pdc_pkg.sv */
package pdc_pkg;

  localparam logic [11:0] PDC_DEVCAP_OFFSET      = 12'h0B4;
  localparam logic [11:0] PDC_STRAP_OFFSET       = 12'h0C0;

  localparam int          PDC_PAYLOAD_LSB        = 0;
  localparam int          PDC_PHANTOM_LSB        = 3;
  localparam int          PDC_TAG8_BIT           = 5;
  localparam int          PDC_L0S_LSB            = 6;
  localparam int          PDC_L1_LSB             = 9;
  localparam int          PDC_ATTN_BTN_BIT       = 12;
  localparam int          PDC_ATTN_IND_BIT       = 13;
  localparam int          PDC_PWR_IND_BIT        = 14;
  localparam int          PDC_PWR_VAL_LSB        = 18;
  localparam int          PDC_PWR_SCALE_LSB      = 26;

  localparam logic [2:0]  PDC_PAYLOAD_RESET      = 3'h1;
  localparam logic [1:0]  PDC_PHANTOM_RESET      = 2'h0;
  localparam logic        PDC_TAG8_RESET         = 1'b1;
  localparam logic [2:0]  PDC_L0S_RESET          = 3'h0;
  localparam logic [2:0]  PDC_L1_RESET           = 3'h0;
  localparam logic [7:0]  PDC_PWR_VAL_RESET      = 8'h00;
  localparam logic [1:0]  PDC_PWR_SCALE_RESET    = 2'h0;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pdc_pwr_msg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_s;

endpackage

/* File: logic/pdc_devcap.sv */
// Operation
// R01 - tag bit reports 8-bit tags supported, reset value one
// R02 - phantom functions field always reads zero
// R03 - L0s latency field uses eight doubling ranges, resets to code zero
// R04 - L1 latency field uses eight doubling ranges, resets to code zero
// R05 - attention button present only when hot-plug enabled in forward mode
// R06 - attention and power indicators present when hot-plug enabled in forward mode
// R07 - presence bits taken from hot-plug strap after reset
// R08 - power limit message value captured into eight-bit field, reset zero
// R09 - power limit message scale captured into two-bit field, reset zero
// R10 - max payload field encodes 128 to 4096 bytes, resets to 256-byte code
// R11 - reserved bits read zero, writes to the capability word ignored
module pdc_devcap #(
  parameter logic [2:0] L0S_LATENCY = pdc_pkg::PDC_L0S_RESET,
  parameter logic [2:0] L1_LATENCY  = pdc_pkg::PDC_L1_RESET
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // straps, from pins
  input  wire logic                  hotplug_strap,
  input  wire logic                  forward_strap,
  // power limit message from the link core, same clock
  input  wire pdc_pkg::pdc_pwr_msg_s pwr_msg,
  // status
  output logic      [31:0]           devcap
);
  import pdc_pkg::*;

  // register targets of the access decoder
  typedef enum logic [1:0] {
    TGT_DEVCAP = 2'b00,
    TGT_STRAP  = 2'b01,
    TGT_NONE   = 2'b10
  } pdc_target_e;

  // strap synchronisers, only the second stage is read
  logic [1:0]  hp_sync_q;
  logic [1:0]  hp_sync_d;
  logic [1:0]  fw_sync_q;
  logic [1:0]  fw_sync_d;
  // synced strap levels
  logic        hp_q;
  logic        hp_d;
  logic        fw_q;
  logic        fw_d;
  // hot-plug presence bits
  logic        attn_btn_q;
  logic        attn_btn_d;
  logic        attn_ind_q;
  logic        attn_ind_d;
  logic        pwr_ind_q;
  logic        pwr_ind_d;
  // fixed fields, held in flops so each carries its own reset value
  logic [2:0]  payload_q;
  logic [2:0]  payload_d;
  logic [1:0]  phantom_q;
  logic [1:0]  phantom_d;
  logic        tag8_q;
  logic        tag8_d;
  logic [2:0]  l0s_q;
  logic [2:0]  l0s_d;
  logic [2:0]  l1_q;
  logic [2:0]  l1_d;
  // captured slot power limit
  logic [7:0]  pwr_val_q;
  logic [7:0]  pwr_val_d;
  logic [1:0]  pwr_scale_q;
  logic [1:0]  pwr_scale_d;
  // assembled word and its registered copy
  logic [31:0] word;
  logic [31:0] devcap_q;
  logic [31:0] devcap_d;
  // apb response
  logic        access;
  pdc_target_e target;
  logic        pready_q;
  logic        pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // hot-plug features exist only on a forward bridge with the strap set
  function automatic logic hp_present(input logic hp, input logic fw);
    return hp & fw;
  endfunction

  // full byte address match, so an unaligned access is refused as unmapped
  function automatic pdc_target_e decode(input logic [11:0] addr);
    pdc_target_e t;
    t = TGT_NONE;
    if (addr == PDC_DEVCAP_OFFSET) begin
      t = TGT_DEVCAP;
    end else if (addr == PDC_STRAP_OFFSET) begin
      t = TGT_STRAP;
    end
    return t;
  endfunction

  always_comb begin
    hp_sync_d = {hp_sync_q[0], hotplug_strap};
    fw_sync_d = {fw_sync_q[0], forward_strap};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_sync_q <= 2'h0;
      fw_sync_q <= 2'h0;
    end else begin
      hp_sync_q <= hp_sync_d;
      fw_sync_q <= fw_sync_d;
    end
  end

  // levels seen by software in the strap status word
  always_comb begin
    hp_d = hp_sync_q[1];                                    // R07
    fw_d = fw_sync_q[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_q <= 1'b0;
      fw_q <= 1'b0;
    end else begin
      hp_q <= hp_d;
      fw_q <= fw_d;
    end
  end

  // straps are static; tracking them also covers the value present at release
  always_comb begin
    attn_btn_d = hp_present(hp_sync_q[1], fw_sync_q[1]);    // R05 R07
    attn_ind_d = hp_present(hp_sync_q[1], fw_sync_q[1]);    // R06 R07
    pwr_ind_d  = hp_present(hp_sync_q[1], fw_sync_q[1]);    // R06 R07
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attn_btn_q <= 1'b0;
      attn_ind_q <= 1'b0;
      pwr_ind_q  <= 1'b0;
    end else begin
      attn_btn_q <= attn_btn_d;
      attn_ind_q <= attn_ind_d;
      pwr_ind_q  <= pwr_ind_d;
    end
  end

  // read-only fields hold their reset value; no bus path can load them
  always_comb begin
    payload_d = payload_q;                                  // R10
    phantom_d = phantom_q;                                  // R02
    tag8_d    = tag8_q;                                     // R01
    l0s_d     = l0s_q;                                      // R03
    l1_d      = l1_q;                                       // R04
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_q <= PDC_PAYLOAD_RESET;
      phantom_q <= PDC_PHANTOM_RESET;
      tag8_q    <= PDC_TAG8_RESET;
      l0s_q     <= L0S_LATENCY;
      l1_q      <= L1_LATENCY;
    end else begin
      payload_q <= payload_d;
      phantom_q <= phantom_d;
      tag8_q    <= tag8_d;
      l0s_q     <= l0s_d;
      l1_q      <= l1_d;
    end
  end

  // the last message wins; nothing queues behind the pulse
  always_comb begin
    pwr_val_d = pwr_val_q;
    if (pwr_msg.valid) begin
      pwr_val_d = pwr_msg.value;                            // R08
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_val_q <= PDC_PWR_VAL_RESET;
    end else begin
      pwr_val_q <= pwr_val_d;
    end
  end

  always_comb begin
    pwr_scale_d = pwr_scale_q;
    if (pwr_msg.valid) begin
      pwr_scale_d = pwr_msg.scale;                          // R09
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_scale_q <= PDC_PWR_SCALE_RESET;
    end else begin
      pwr_scale_q <= pwr_scale_d;
    end
  end

  always_comb begin
    // reserved ranges keep the zero of the first assignment
    word                             = 32'h0000_0000;       // R11
    word[PDC_PAYLOAD_LSB +: 3]       = payload_q;           // R10
    word[PDC_PHANTOM_LSB +: 2]       = phantom_q;           // R02
    word[PDC_TAG8_BIT]               = tag8_q;              // R01
    word[PDC_L0S_LSB +: 3]           = l0s_q;               // R03
    word[PDC_L1_LSB +: 3]            = l1_q;                // R04
    word[PDC_ATTN_BTN_BIT]           = attn_btn_q;          // R05
    word[PDC_ATTN_IND_BIT]           = attn_ind_q;          // R06
    word[PDC_PWR_IND_BIT]            = pwr_ind_q;           // R06
    word[PDC_PWR_VAL_LSB +: 8]       = pwr_val_q;           // R08
    word[PDC_PWR_SCALE_LSB +: 2]     = pwr_scale_q;         // R09
    // devcap lags the word by one flop, reads see the word itself
    devcap_d = word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      devcap_q <= 32'h0000_0000;
    end else begin
      devcap_q <= devcap_d;
    end
  end

  always_comb begin
    // one wait state so read data and error come straight from flops
    access   = psel & penable & ~pready_q;
    pready_d = access;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_comb begin
    target   = decode(paddr);
    prdata_d = 32'h0000_0000;
    // writes to a mapped word are accepted and dropped
    if (access && !pwrite) begin                            // R11
      unique case (target)
        TGT_DEVCAP: begin
          prdata_d = word;
        end
        TGT_STRAP: begin
          // bit 0 hot-plug strap, bit 1 forward strap
          prdata_d = {30'h0, fw_q, hp_q};
        end
        TGT_NONE: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  always_comb begin
    pslverr_d = 1'b0;
    // only an unmapped word is refused, in either direction
    if (access && target == TGT_NONE) begin
      pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign devcap  = devcap_q;

endmodule

/* File: testbench/pdc_devcap_checker.sv */
module pdc_devcap_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  hotplug_strap,
  input wire logic                  forward_strap,
  input wire pdc_pkg::pdc_pwr_msg_s pwr_msg,
  input wire logic [31:0]           devcap
);
  timeunit 1ns;
  timeprecision 1ns;
  import pdc_pkg::*;
  logic up_q;
  // devcap still shows reset zeros at the first edge after release
  always_ff @(posedge pclk or negedge presetn) if (!presetn) up_q <= 1'b0; else up_q <= 1'b1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_msg; pwr_msg.valid ##1 !pwr_msg.valid; endsequence
  chk_tag_bit: assert property (up_q |-> devcap[5]) else $error("tag bit low");
  chk_phantom_zero: assert property (up_q |-> devcap[4:3] == 2'h0) else $error("phantom set");
  chk_l0s_code: assert property (up_q |-> devcap[8:6] == 3'h0) else $error("l0s code");
  chk_l1_code: assert property (up_q |-> devcap[11:9] == 3'h0) else $error("l1 code");
  chk_payload_code: assert property (up_q |-> devcap[2:0] == 3'h1) else $error("payload");
  chk_rsvd_zero: assert property (up_q |-> {devcap[31:28], devcap[17:15]} == 7'h0) else $error("rsvd");
  chk_pwr_value: assert property (s_msg |=> devcap[25:18] == $past(pwr_msg.value, 2)) else $error("value");
  chk_pwr_scale: assert property (s_msg |=> devcap[27:26] == $past(pwr_msg.scale, 2)) else $error("scale");
  chk_hp_on: assert property ((hotplug_strap && forward_strap)[*7] |-> devcap[14:12] == 3'h7) else $error("hp on");
  chk_hp_off: assert property ((!forward_strap)[*7] |-> devcap[14:12] == 3'h0) else $error("hp off");
  chk_hp_dis: assert property ((!hotplug_strap)[*7] |-> devcap[14:12] == 3'h0) else $error("hp disabled");
endmodule
bind pdc_devcap pdc_devcap_checker pdc_devcap_checker_inst (.pclk, .presetn, .hotplug_strap, .forward_strap,
  .pwr_msg, .devcap);

/* File: testbench/pdc_link_model.sv */
module pdc_link_model (
  input  wire logic           pclk,
  output pdc_pkg::pdc_pwr_msg_s msg
);
  timeunit 1ns;
  timeprecision 1ns;
  import pdc_pkg::*;
  initial msg = '0;
  // payload is scrambled after the pulse so a core sampling late cannot match
  task send(input logic [7:0] v, input logic [1:0] s);
    @(posedge pclk) msg <= '{1'b1, v, s};
    @(posedge pclk) msg <= '{1'b0, ~v, ~s};
  endtask
endmodule

/* File: testbench/pcie_device_capability_reg_test.sv */
module pcie_device_capability_reg_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pdc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hp = 1, fw = 1, pe, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, devcap, rd;
  logic [7:0] pv = 0;
  logic [1:0] ps = 0;
  pdc_pwr_msg_s msg;
  int error_cnt = 0, checks = 0;
  always #10 pclk = ~pclk;
  pdc_devcap pdc_devcap_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hotplug_strap(hp), .forward_strap(fw), .pwr_msg(msg), .devcap);
  pdc_link_model pdc_link_model_inst (.pclk, .msg);
  function automatic logic [31:0] expw();
    return {4'h0, ps, pv, 3'h0, {3{hp & fw}}, 6'h0, 1'b1, 2'h0, 3'h1};
  endfunction
  task wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask
  task xfer(input logic [11:0] a, input logic w);
    int n;
    @(posedge pclk) {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, 32'hFFFF_FFFF};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin error_cnt++; wrap_up; end
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset; xfer(PDC_DEVCAP_OFFSET, 0); cmp(rd, expw()); cmp(devcap, expw()); endtask
  task t_write;
    xfer(PDC_DEVCAP_OFFSET, 1);
    cmp({31'h0, pe}, 32'h0000_0000);
    xfer(PDC_STRAP_OFFSET, 1);
    cmp({31'h0, pe}, 32'h0000_0000);
    xfer(PDC_DEVCAP_OFFSET, 0);
    cmp(rd, expw());
  endtask
  task t_msg;
    for (int i = 0; i < 2; i++) begin
      pv = i ? 8'h5A : 8'hA5;
      ps = i ? 2'h1 : 2'h2;
      pdc_link_model_inst.send(pv, ps);
      xfer(PDC_DEVCAP_OFFSET, 0);
      cmp(rd, expw());
      cmp(devcap, expw());
    end
  endtask
  task t_strap(input logic h, input logic f);
    @(posedge pclk) {hp, fw} <= {h, f};
    repeat (8) @(posedge pclk);
    xfer(PDC_DEVCAP_OFFSET, 0); cmp(rd, expw());
    xfer(PDC_STRAP_OFFSET, 0); cmp(rd, {30'h0, fw, hp});
  endtask
  task t_bad;
    xfer(12'h0B8, 0);
    cmp(rd, 32'h0000_0000);
    cmp({31'h0, pe}, 32'h0000_0001);
    xfer(12'h0B8, 1);
    cmp({31'h0, pe}, 32'h0000_0001);
  endtask
  // mid-run reset: captured power fields must return to zero
  task t_rst;
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) cmp(devcap, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pv = 8'h00;
    ps = 2'h0;
    repeat (6) @(posedge pclk);
    xfer(PDC_DEVCAP_OFFSET, 0);
    cmp(rd, expw());
    cmp(devcap, expw());
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_reset;
    t_write;
    t_msg;
    t_rst;
    t_strap(1'b1, 1'b0);
    t_strap(1'b0, 1'b1);
    t_bad;
    wrap_up;
  end
endmodule
